// [irq_prio_pkg.sv]
// Constants, field tables and carrier types of the priority-level register slice.
// Notes on behaviour
// - A 2-bit field reads 00 for a disabled request and 01, 10, 11 for levels 0, 1 and 2.
// - After reset every priority field holds 00, so every covered request is disabled.
// - Bits 5-4 of the sixth register and bits 11-10 of the eighth read as zero and ignore writes.
// - Bits 7-6 of the sixth register hold the level of timer D channel 0.
// - Bits 3-2 of the sixth register hold the level of the decoder 0 index request.
// - Bits 1-0 of the sixth register hold the level of the shared decoder 0 home or watchdog request.
// - The seventh register, at offset 7, holds timer A channel 0 in bits 15-14.
// - The seventh register holds timer B channels 3 to 0 in bits 13-12 down to 7-6.
// - The seventh register holds timer C channels 3, 2 and 1 in bits 5-4, 3-2 and 1-0.
// - The eighth register, at offset 8, holds serial 0 receive full in 15-14 and receive error in 13-12.
// - The eighth register holds serial 0 transmit idle in bits 9-8 and transmit empty in bits 7-6.
// - The eighth register holds timer A channels 3, 2 and 1 in bits 5-4, 3-2 and 1-0.
// - The sixth register, of which the low byte is held here, sits at offset 6.
package irq_prio_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned REG_W = 16;
   localparam int unsigned STRB_W = 4;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned FIELD_W = 2;
   localparam int unsigned NUM_FIELDS = 18;
   localparam int unsigned WORD_BYTES = 4;
   localparam int unsigned WORD_LSB = 2;
   localparam int unsigned IDX_SIXTH = 6;
   localparam int unsigned IDX_SEVENTH = 7;
   localparam int unsigned IDX_EIGHTH = 8;
   localparam logic [ADDR_W-1:0] ADDR_SIXTH = ADDR_W'(IDX_SIXTH * WORD_BYTES);
   localparam logic [ADDR_W-1:0] ADDR_SEVENTH = ADDR_W'(IDX_SEVENTH * WORD_BYTES);
   localparam logic [ADDR_W-1:0] ADDR_EIGHTH = ADDR_W'(IDX_EIGHTH * WORD_BYTES);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] CODE_OFF = 2'h0;
   localparam logic [1:0] CODE_LVL0 = 2'h1;
   localparam logic [1:0] LEVEL_NONE = 2'h0;
   localparam logic [1:0] REG_SIXTH = 2'h0;
   localparam logic [1:0] REG_SEVENTH = 2'h1;
   localparam logic [1:0] REG_EIGHTH = 2'h2;
   localparam logic [1:0] REG_NONE = 2'h3;
   // Field i sits at bits 2i+1:2i of the flat vector; index 0 is timer A channel 1.
   localparam logic [1:0] FIELD_REG [NUM_FIELDS] = '{
      REG_EIGHTH, REG_EIGHTH, REG_EIGHTH, REG_EIGHTH, REG_EIGHTH, REG_EIGHTH, REG_EIGHTH,
      REG_SEVENTH, REG_SEVENTH, REG_SEVENTH, REG_SEVENTH, REG_SEVENTH, REG_SEVENTH, REG_SEVENTH,
      REG_SEVENTH, REG_SIXTH, REG_SIXTH, REG_SIXTH};
   // No field sits on the reserved pairs, so they have no flop and read as zero.
   localparam int unsigned FIELD_POS [NUM_FIELDS] = '{
      0, 2, 4, 6, 8, 12, 14,
      0, 2, 4, 6, 8, 10, 12, 14,
      0, 2, 6};
   typedef struct packed {
      logic [1:0] timer_d_chan0_level;
      logic [1:0] decoder0_index_level;
      logic [1:0] decoder0_home_watchdog_level;
      logic [1:0] timer_a_chan0_level;
      logic [1:0] timer_b_chan3_level;
      logic [1:0] timer_b_chan2_level;
      logic [1:0] timer_b_chan1_level;
      logic [1:0] timer_b_chan0_level;
      logic [1:0] timer_c_chan3_level;
      logic [1:0] timer_c_chan2_level;
      logic [1:0] timer_c_chan1_level;
      logic [1:0] serial0_rx_full_level;
      logic [1:0] serial0_rx_error_level;
      logic [1:0] serial0_tx_idle_level;
      logic [1:0] serial0_tx_empty_level;
      logic [1:0] timer_a_chan3_level;
      logic [1:0] timer_a_chan2_level;
      logic [1:0] timer_a_chan1_level;
   } prio_levels_t;
   typedef struct packed {
      logic [REG_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } reg_write_t;
endpackage

// [prio_field_reg.sv]
// One software-written 2-bit priority field with byte-lane write enable.
`timescale 1ns/10ps
`default_nettype none
module prio_field_reg #(
   parameter int unsigned POS = 0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write side
   input wire logic sel,
   input wire irq_prio_pkg::reg_write_t wr,
   // Stored code
   output logic [irq_prio_pkg::FIELD_W-1:0] code_q
);
   import irq_prio_pkg::*;
   localparam int unsigned LANE = POS / BYTE_W;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_q <= CODE_OFF;
      end else if (sel && wr.strb[LANE]) begin
         code_q <= wr.data[POS +: FIELD_W];
      end
   end
endmodule
`default_nettype wire

// [prio_level_decode.sv]
// Registered decode of a priority code into an enable and a level number.
`timescale 1ns/10ps
`default_nettype none
module prio_level_decode (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Field code
   input wire logic [1:0] code,
   // Decoded request setup
   output logic en_q,
   output logic [1:0] num_q
);
   import irq_prio_pkg::*;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 1'b0;
         num_q <= LEVEL_NONE;
      end else begin
         en_q <= (code != CODE_OFF);
         num_q <= (code == CODE_OFF) ? LEVEL_NONE : 2'(code - CODE_LVL0);
      end
   end
endmodule
`default_nettype wire

// [irq_prio_regs.sv]
// AXI4-Lite register bank for the priority-level fields of the sixth to eighth registers.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module irq_prio_regs (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic awvalid,
   output logic awready,
   input wire logic [irq_prio_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // Write data channel
   input wire logic wvalid,
   output logic wready,
   input wire logic [irq_prio_pkg::DATA_W-1:0] wdata,
   input wire logic [irq_prio_pkg::STRB_W-1:0] wstrb,
   // Write response channel
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // Read address channel
   input wire logic arvalid,
   output logic arready,
   input wire logic [irq_prio_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // Read data channel
   output logic rvalid,
   input wire logic rready,
   output logic [irq_prio_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // Priority setup toward the arbiter
   output irq_prio_pkg::prio_levels_t field_code,
   output logic [irq_prio_pkg::NUM_FIELDS-1:0] req_enable,
   output irq_prio_pkg::prio_levels_t req_level
);
   import irq_prio_pkg::*;

   // ----------------------------------------------------------------
   // Address decode and read image
   // ----------------------------------------------------------------

   function automatic logic [1:0] reg_of(input logic [ADDR_W-1:0] a);
      logic [1:0] id;
      id = REG_NONE;
      if (a[ADDR_W-1:WORD_LSB] == ADDR_SIXTH[ADDR_W-1:WORD_LSB]) begin
         id = REG_SIXTH;
      end else if (a[ADDR_W-1:WORD_LSB] == ADDR_SEVENTH[ADDR_W-1:WORD_LSB]) begin
         id = REG_SEVENTH;
      end else if (a[ADDR_W-1:WORD_LSB] == ADDR_EIGHTH[ADDR_W-1:WORD_LSB]) begin
         id = REG_EIGHTH;
      end
      return id;
   endfunction

   // Bits owned by no field, the reserved pairs among them, stay zero.
   function automatic logic [REG_W-1:0] reg_image(
      input logic [1:0] id,
      input logic [FIELD_W*NUM_FIELDS-1:0] flat
   );
      logic [REG_W-1:0] img;
      img = '0;
      for (int i = 0; i < NUM_FIELDS; i++) begin
         if (FIELD_REG[i] == id) begin
            img[FIELD_POS[i] +: FIELD_W] = flat[i*FIELD_W +: FIELD_W];
         end
      end
      return img;
   endfunction

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------

   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic aw_have_q;
   logic w_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   reg_write_t wr_q;
   logic aw_have_d;
   logic w_have_d;
   logic bvalid_d;
   logic aw_hs;
   logic w_hs;
   logic b_hs;
   logic wr_fire;
   logic [1:0] wr_reg;

   assign aw_hs = awvalid && awready_q;
   assign w_hs = wvalid && wready_q;
   assign b_hs = bvalid_q && bready;
   // The write takes effect once both halves are held and no answer is pending.
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_reg = reg_of(awaddr_q);

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      bvalid_d = bvalid_q;
      if (aw_hs) begin
         aw_have_d = 1'b1;
      end else if (wr_fire) begin
         aw_have_d = 1'b0;
      end
      if (w_hs) begin
         w_have_d = 1'b1;
      end else if (wr_fire) begin
         w_have_d = 1'b0;
      end
      if (wr_fire) begin
         bvalid_d = 1'b1;
      end else if (b_hs) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         bvalid_q <= bvalid_d;
         // A channel reopens only after the previous response is taken.
         awready_q <= !aw_have_d && !bvalid_d;
         wready_q <= !w_have_d && !bvalid_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= '0;
      end else if (aw_hs) begin
         awaddr_q <= awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_q <= '0;
      end else if (w_hs) begin
         wr_q.data <= wdata[REG_W-1:0];
         wr_q.strb <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bresp_q <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   // ----------------------------------------------------------------
   // Priority fields
   // ----------------------------------------------------------------

   logic [FIELD_W*NUM_FIELDS-1:0] code_flat;
   logic [FIELD_W*NUM_FIELDS-1:0] num_flat;
   logic [NUM_FIELDS-1:0] en_flat;

   for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
      prio_field_reg #(
         .POS(FIELD_POS[i])
      ) u_field (
         .aclk(aclk),
         .aresetn(aresetn),
         .sel(wr_fire && (wr_reg == FIELD_REG[i])),
         .wr(wr_q),
         .code_q(code_flat[i*FIELD_W +: FIELD_W])
      );
      prio_level_decode u_dec (
         .aclk(aclk),
         .aresetn(aresetn),
         .code(code_flat[i*FIELD_W +: FIELD_W]),
         .en_q(en_flat[i]),
         .num_q(num_flat[i*FIELD_W +: FIELD_W])
      );

      chk_decode_off: assert property (@(posedge aclk) disable iff (!aresetn)
         code_flat[i*FIELD_W +: FIELD_W] == CODE_OFF |=> !en_flat[i] && num_flat[i*FIELD_W +: FIELD_W] == LEVEL_NONE)
         else $error("disabled code gave an enabled request");
      chk_decode_level: assert property (@(posedge aclk) disable iff (!aresetn)
         code_flat[i*FIELD_W +: FIELD_W] != CODE_OFF
         |=> en_flat[i] && num_flat[i*FIELD_W +: FIELD_W] == $past(code_flat[i*FIELD_W +: FIELD_W]) - CODE_LVL0)
         else $error("level number does not follow the code");
   end

   // Field codes are the field flops themselves; the decoded view lags by one cycle.
   assign field_code = prio_levels_t'(code_flat);
   assign req_level = prio_levels_t'(num_flat);
   assign req_enable = en_flat;

   // ----------------------------------------------------------------
   // Read channels
   // ----------------------------------------------------------------

   logic arready_q;
   logic rvalid_q;
   logic rvalid_d;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   logic [1:0] rd_reg_q;
   logic ar_hs;
   logic r_hs;

   assign ar_hs = arvalid && arready_q;
   assign r_hs = rvalid_q && rready;

   always_comb begin
      rvalid_d = rvalid_q;
      if (ar_hs) begin
         rvalid_d = 1'b1;
      end else if (r_hs) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         rvalid_q <= rvalid_d;
         arready_q <= !rvalid_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
         rd_reg_q <= REG_NONE;
      end else if (ar_hs) begin
         rdata_q <= DATA_W'(reg_image(reg_of(araddr), code_flat));
         rresp_q <= (reg_of(araddr) == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         rd_reg_q <= reg_of(araddr);
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   logic [REG_W-1:0] wr_img_q;
   logic [STRB_W-1:0] wr_strb_q;
   logic [1:0] wr_reg_q;
   logic wr_done_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_img_q <= '0;
         wr_strb_q <= '0;
         wr_reg_q <= REG_NONE;
         wr_done_q <= 1'b0;
      end else begin
         wr_img_q <= wr_q.data;
         wr_strb_q <= wr_q.strb;
         wr_reg_q <= wr_reg;
         wr_done_q <= wr_fire;
      end
   end

   chk_reset_fields: assert property (@(posedge aclk)
      !aresetn |=> field_code == '0)
      else $error("a field is not 00 after reset");

   chk_sixth_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_q && rd_reg_q == REG_SIXTH |-> rdata_q[5:4] == 2'h0 && rdata_q[DATA_W-1:BYTE_W] == '0)
      else $error("reserved bits of the sixth register read nonzero");

   chk_eighth_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_q && rd_reg_q == REG_EIGHTH |-> rdata_q[11:10] == 2'h0 && rdata_q[DATA_W-1:REG_W] == '0)
      else $error("reserved bits of the eighth register read nonzero");

   chk_timer_d_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_SIXTH && wr_strb_q[0] |-> field_code.timer_d_chan0_level == wr_img_q[7:6])
      else $error("timer D channel 0 field did not take the write");

   chk_index_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_SIXTH && wr_strb_q[0] |-> field_code.decoder0_index_level == wr_img_q[3:2])
      else $error("decoder index field did not take the write");

   chk_home_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_SIXTH && wr_strb_q[0]
      |-> field_code.decoder0_home_watchdog_level == wr_img_q[1:0])
      else $error("home or watchdog field did not take the write");

   chk_seventh_top: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_SEVENTH && wr_strb_q[1] |-> field_code.timer_a_chan0_level == wr_img_q[15:14])
      else $error("timer A channel 0 field did not take the write");

   chk_seventh_timer_b: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_SEVENTH && wr_strb_q[1:0] == 2'h3
      |-> {field_code.timer_b_chan3_level, field_code.timer_b_chan2_level,
           field_code.timer_b_chan1_level, field_code.timer_b_chan0_level} == wr_img_q[13:6])
      else $error("timer B fields did not take the write");

   chk_seventh_timer_c: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_SEVENTH && wr_strb_q[0]
      |-> {field_code.timer_c_chan3_level, field_code.timer_c_chan2_level,
           field_code.timer_c_chan1_level} == wr_img_q[5:0])
      else $error("timer C fields did not take the write");

   chk_eighth_receive: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_EIGHTH && wr_strb_q[1]
      |-> {field_code.serial0_rx_full_level, field_code.serial0_rx_error_level} == wr_img_q[15:12])
      else $error("serial receive fields did not take the write");

   chk_eighth_transmit: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_EIGHTH && wr_strb_q[1:0] == 2'h3
      |-> {field_code.serial0_tx_idle_level, field_code.serial0_tx_empty_level} == wr_img_q[9:6])
      else $error("serial transmit fields did not take the write");

   chk_eighth_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_done_q && wr_reg_q == REG_EIGHTH && wr_strb_q[0]
      |-> {field_code.timer_a_chan3_level, field_code.timer_a_chan2_level,
           field_code.timer_a_chan1_level} == wr_img_q[5:0])
      else $error("timer A channel 3 to 1 fields did not take the write");

   chk_sixth_address: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && araddr == ADDR_SIXTH |=> rvalid_q && rresp_q == RESP_OKAY && rdata_q[BYTE_W-1:0] ==
      {$past(code_flat[35:34]), 2'h0, $past(code_flat[33:32]), $past(code_flat[31:30])})
      else $error("sixth register read does not show its fields");

   chk_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && araddr == ADDR_SEVENTH |=> rdata_q == DATA_W'($past(code_flat[29:14])))
      else $error("seventh register read does not match stored fields");

   chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> bvalid_q ##0 (bvalid_q throughout (!awready_q && !wready_q)[*1]))
      else $error("write answer did not follow the commit");
endmodule
`default_nettype wire

// [irq_prio_regs_tb.sv]
// Self-checking testbench of the priority-level register bank, driven over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module irq_prio_regs_tb;
   import irq_prio_pkg::*;
   // ----------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [DATA_W-1:0] wdata, rdata;
   logic [STRB_W-1:0] wstrb;
   logic [1:0] bresp, rresp;
   prio_levels_t field_code, req_level;
   logic [NUM_FIELDS-1:0] req_enable;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [15:0] img [3];
   // Reserved pairs and the upper byte of the sixth register are masked off in the model.
   logic [15:0] mask [3] = '{16'h00cf, 16'hffff, 16'hf3ff};
   logic [7:0] bad [2] = '{8'h24, 8'h14};
   irq_prio_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .field_code(field_code), .req_enable(req_enable), .req_level(req_level));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // ----------------------------------------------------------------
   // Expectation functions
   // ----------------------------------------------------------------
   function automatic logic [7:0] reg_addr(input int i);
      return 8'(24 + 4 * i);
   endfunction
   function automatic prio_levels_t exp_fields();
      return prio_levels_t'({img[0][7:6], img[0][3:0], img[1], img[2][15:12], img[2][9:0]});
   endfunction
   function automatic logic [NUM_FIELDS-1:0] exp_en(input prio_levels_t f);
      logic [NUM_FIELDS-1:0] e;
      for (int i = 0; i < NUM_FIELDS; i++) begin
         e[i] = (f[2*i +: 2] != 2'h0);
      end
      return e;
   endfunction
   function automatic prio_levels_t exp_lvl(input prio_levels_t f);
      prio_levels_t l;
      for (int i = 0; i < NUM_FIELDS; i++) begin
         l[2*i +: 2] = (f[2*i +: 2] == 2'h0) ? 2'h0 : f[2*i +: 2] - 2'h1;
      end
      return l;
   endfunction
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      awprot <= 3'($urandom);
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      arprot <= 3'($urandom);
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic model_write(input int k, input logic [31:0] d, input logic [3:0] s);
      if (s[0]) img[k][7:0] = d[7:0] & mask[k][7:0];
      if (s[1]) img[k][15:8] = d[15:8] & mask[k][15:8];
   endtask
   task automatic check_all();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 3; i++) begin
         axi_read(reg_addr(i), d, r);
         `CHK("rdata", {16'h0000, img[i]}, d)
         `CHK("rresp", RESP_OKAY, r)
      end
      `CHK("field_code", exp_fields(), field_code)
      `CHK("req_enable", exp_en(exp_fields()), req_enable)
      `CHK("req_level", exp_lvl(exp_fields()), req_level)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Timeout
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      cycles++;
      if (cycles >= 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [3:0] s;
      logic [1:0] r;
      int k;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      awprot = 3'h0;
      arprot = 3'h0;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      aresetn = 1'b0;
      img = '{16'h0000, 16'h0000, 16'h0000};
      void'($urandom(78));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      check_all();
      // Every code in every field, the same code pushed into the reserved pairs and ones into bits 31-16.
      for (int c = 0; c < 4; c++) begin
         for (k = 0; k < 3; k++) begin
            d = {16'hffff, {8{2'(c)}}};
            axi_write(reg_addr(k), d, 4'h3, r);
            `CHK("bresp", RESP_OKAY, r)
            model_write(k, d, 4'h3);
         end
         check_all();
      end
      for (int n = 0; n < 60; n++) begin
         k = $urandom_range(0, 4);
         d = $urandom;
         s = 4'($urandom);
         if (k < 3) begin
            axi_write(reg_addr(k), d, s, r);
            `CHK("bresp", RESP_OKAY, r)
            model_write(k, d, s);
         end else begin
            axi_write(bad[k-3], d, s, r);
            `CHK("bresp_unmapped", RESP_SLVERR, r)
            axi_read(bad[k-3], d, r);
            `CHK("rresp_unmapped", RESP_SLVERR, r)
            `CHK("rdata_unmapped", 32'h0000_0000, d)
         end
         check_all();
      end
      // A second reset in mid-run must clear every field again.
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      img = '{16'h0000, 16'h0000, 16'h0000};
      check_all();
      report_and_stop();
   end
endmodule
`default_nettype wire
